/* pulse_cfg_pkg.sv */
// Package with offsets, fields, reset values and timing for pulse config
package pulse_cfg_pkg;

  localparam int DATA_W = 24;
  localparam int ADDR_W = 6;

  // Register offsets on the device's register port
  localparam logic [5:0] OFS_TIME_LEVEL   = 6'h1F;
  localparam logic [5:0] OFS_INPUT_ENABLE = 6'h20;
  localparam logic [5:0] OFS_THRESHOLD    = 6'h21;

  // Field positions
  localparam int DUR_LSB   = 4;
  localparam int DUR_W     = 3;
  localparam int LEVEL_LSB = 0;
  localparam int LEVEL_W   = 4;
  localparam int THR_W     = 2;
  localparam int N_INPUTS  = 24;
  localparam int N_LEVEL_GROUPS = 4;
  localparam int LEVEL_GROUP_SIZE = 6;
  localparam int N_THR_GROUPS = 6;
  localparam int THR_GROUP_SIZE = 4;

  // Writable masks, all other bits reserved
  localparam logic [23:0] MASK_TIME_LEVEL = 24'h00007F;
  localparam logic [23:0] MASK_INPUT_EN   = 24'hFFFFFF;
  localparam logic [23:0] MASK_THRESHOLD  = 24'h000FFF;

  // Reset values
  localparam logic [23:0] RST_TIME_LEVEL = 24'h000000;
  localparam logic [23:0] RST_INPUT_EN   = 24'h000000;
  localparam logic [23:0] RST_THRESHOLD  = 24'h000000;

  // Pulse timing: one duration step in ns, clock period in ns
  localparam int STEP_NS    = 64000;
  localparam int CLK_NS     = 4;
  localparam int STEP_CYCLES = STEP_NS / CLK_NS;
  localparam int CNT_W      = 18;

  // Level and threshold encodings
  typedef enum logic {LEVEL_10MA = 1'h0, LEVEL_15MA = 1'h1} level_t;
  typedef enum logic [1:0] {
    THR_2V0 = 2'h0, THR_2V7 = 2'h1, THR_3V0 = 2'h2, THR_4V0 = 2'h3
  } thr_t;

  // Register access request
  typedef struct packed {
    logic              wr;
    logic              rd;
    logic [5:0]        addr;
    logic [23:0]       wdata;
  } reg_req_t;

  // Drive to the wetting current sources
  typedef struct packed {
    logic [23:0] on;
    logic [23:0] high_level;
  } pulse_drive_t;

endpackage : pulse_cfg_pkg

/* pulse_timer.sv */
// Cleaning pulse timer: counts duration steps of 64 us
`timescale 1ns/1ps
module pulse_timer (
  input  wire logic       ref_clk,
  input  wire logic       rst,
  input  wire logic       start,
  input  wire logic [2:0] dur_code,
  output logic            active
);

  logic [17:0] cyc_r;
  logic [3:0]  steps_r;
  logic        active_r;

  // Run flag leaves the module straight from its flip-flop
  assign active = active_r;

  // Load (code+1) steps on start, run down one step per 64 us
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cyc_r    <= 18'h00000;
      steps_r  <= 4'h0;
      active_r <= 1'h0;
    end else if (start && !active_r) begin
      cyc_r    <= 18'(pulse_cfg_pkg::STEP_CYCLES - 1);
      steps_r  <= {1'h0, dur_code} + 4'h1; // R1
      active_r <= 1'h1;
    end else if (active_r) begin
      if (cyc_r == 18'h00000) begin
        cyc_r <= 18'(pulse_cfg_pkg::STEP_CYCLES - 1);
        if (steps_r == 4'h1) begin
          active_r <= 1'h0;
          steps_r  <= 4'h0;
        end else begin
          steps_r <= steps_r - 4'h1;
        end
      end else begin
        cyc_r <= cyc_r - 18'h00001;
      end
    end
  end

endmodule : pulse_timer

/* pulse_threshold_cfg.sv */
// Cleaning pulse and comparator threshold configuration registers
`timescale 1ns/1ps
// Notes on behaviour
// R1: Bits 6-4 set the pulse duration as (code+1) steps of 64 us.
// R2: Bit 3 picks 10 mA (0) or 15 mA (1) pulse current for inputs 18-23.
// R3: Bit 2 picks 10 mA (0) or 15 mA (1) pulse current for inputs 12-17.
// R4: Bit 1 picks 10 mA (0) or 15 mA (1) pulse current for inputs 6-11.
// R5: Bit 0 picks 10 mA (0) or 15 mA (1) pulse current for inputs 0-5.
// R6: One enable bit per input, bit n for input n, one turns the pulse on.
// R7: Six 2-bit threshold fields in bits 11-0, each for four inputs.
// R8: Threshold code 0,1,2,3 selects 2 V, 2.7 V, 3 V, 4 V.
// R9: Reserved bits read as zero and ignore writes.
// R10: A pulse drives only enabled inputs at their group level and duration.
module pulse_threshold_cfg (
  input  wire logic                     ref_clk,
  input  wire logic                     rst,
  input  wire pulse_cfg_pkg::reg_req_t  req,
  input  wire logic                     pulse_start,
  output logic [23:0]                   rdata,
  output logic                          rvalid,
  output pulse_cfg_pkg::pulse_drive_t   drive,
  output logic [2:0]                    pulse_duration_code,
  output logic [47:0]                   threshold_per_input,
  output logic                          pulse_busy
);

  // Stored configuration words, reserved bits never set
  logic [23:0] time_level_r;
  logic [23:0] input_enable_r;
  logic [23:0] threshold_r;

  // Address decode and qualified write strobes
  logic        sel_time_level;
  logic        sel_input_enable;
  logic        sel_threshold;
  logic        wr_time_level;
  logic        wr_input_enable;
  logic        wr_threshold;

  // Named fields of the time and level word
  logic [2:0]  dur_field;
  logic        pulse_level_group0;
  logic        pulse_level_group1;
  logic        pulse_level_group2;
  logic        pulse_level_group3;

  // Named threshold fields, one per group of four inputs
  logic [1:0]  threshold_inputs_0_3;
  logic [1:0]  threshold_inputs_4_7;
  logic [1:0]  threshold_inputs_8_11;
  logic [1:0]  threshold_inputs_12_15;
  logic [1:0]  threshold_inputs_16_19;
  logic [1:0]  threshold_inputs_20_23;

  // Group views, per-input spread and read mux output
  logic [3:0]  level_groups;
  logic [11:0] thr_groups;
  logic [23:0] level_per_input;
  logic [47:0] thr_per_input;
  logic [23:0] read_word;
  logic        timer_active;

  // Masked write so reserved bits never store anything
  function automatic logic [23:0] masked(input logic [23:0] d,
                                         input logic [23:0] m);
    masked = d & m;
  endfunction : masked

  // High when a request address hits the given register offset
  function automatic logic addr_hit(input logic [5:0] a,
                                    input logic [5:0] ofs);
    addr_hit = (a == ofs);
  endfunction : addr_hit

  // Group that an input belongs to, for a given group size
  function automatic int group_of(input int idx,
                                  input int size);
    group_of = idx / size;
  endfunction : group_of

  // Address decode, shared by the write and read paths
  assign sel_time_level   = addr_hit(req.addr,
                                     pulse_cfg_pkg::OFS_TIME_LEVEL);
  assign sel_input_enable = addr_hit(req.addr,
                                     pulse_cfg_pkg::OFS_INPUT_ENABLE);
  assign sel_threshold    = addr_hit(req.addr,
                                     pulse_cfg_pkg::OFS_THRESHOLD);

  // Writes act only on the addressed register
  assign wr_time_level   = req.wr & sel_time_level;
  assign wr_input_enable = req.wr & sel_input_enable;
  assign wr_threshold    = req.wr & sel_threshold;

  // Pulse timing configuration register
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      time_level_r <= pulse_cfg_pkg::RST_TIME_LEVEL;
    end else if (wr_time_level) begin
      time_level_r <= masked(req.wdata,
                             pulse_cfg_pkg::MASK_TIME_LEVEL); // R9
    end
  end

  // Per-input pulse enables
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      input_enable_r <= pulse_cfg_pkg::RST_INPUT_EN;
    end else if (wr_input_enable) begin
      input_enable_r <= masked(req.wdata,
                               pulse_cfg_pkg::MASK_INPUT_EN); // R6
    end
  end

  // Comparator threshold register
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      threshold_r <= pulse_cfg_pkg::RST_THRESHOLD;
    end else if (wr_threshold) begin
      threshold_r <= masked(req.wdata,
                            pulse_cfg_pkg::MASK_THRESHOLD); // R7 R9
    end
  end

  // Word returned for the read address, zero when unmapped
  always_comb begin
    read_word = 24'h000000;
    if (sel_time_level) begin
      read_word = masked(time_level_r,
                         pulse_cfg_pkg::MASK_TIME_LEVEL); // R9
    end else if (sel_input_enable) begin
      read_word = input_enable_r; // R6
    end else if (sel_threshold) begin
      read_word = masked(threshold_r,
                         pulse_cfg_pkg::MASK_THRESHOLD); // R9
    end
  end

  // Read strobe answered one cycle later, for one cycle
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rvalid <= 1'h0;
    end else begin
      rvalid <= req.rd;
    end
  end

  // Read data register, holds the last word read
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rdata <= 24'h000000;
    end else if (req.rd) begin
      rdata <= read_word;
    end
  end

  // Duration field and one current level bit per group of six inputs
  assign dur_field = time_level_r[pulse_cfg_pkg::DUR_LSB +:
                                  pulse_cfg_pkg::DUR_W]; // R1
  assign pulse_level_group0 =
    time_level_r[pulse_cfg_pkg::LEVEL_LSB]; // R5
  assign pulse_level_group1 =
    time_level_r[pulse_cfg_pkg::LEVEL_LSB + 1]; // R4
  assign pulse_level_group2 =
    time_level_r[pulse_cfg_pkg::LEVEL_LSB + 2]; // R3
  assign pulse_level_group3 =
    time_level_r[pulse_cfg_pkg::LEVEL_LSB + 3]; // R2
  assign level_groups = {pulse_level_group3, pulse_level_group2,
                         pulse_level_group1, pulse_level_group0};

  // Two-bit threshold code per group of four inputs
  assign threshold_inputs_0_3   =
    threshold_r[0 * pulse_cfg_pkg::THR_W +: pulse_cfg_pkg::THR_W]; // R7
  assign threshold_inputs_4_7   =
    threshold_r[1 * pulse_cfg_pkg::THR_W +: pulse_cfg_pkg::THR_W]; // R7
  assign threshold_inputs_8_11  =
    threshold_r[2 * pulse_cfg_pkg::THR_W +: pulse_cfg_pkg::THR_W]; // R7
  assign threshold_inputs_12_15 =
    threshold_r[3 * pulse_cfg_pkg::THR_W +: pulse_cfg_pkg::THR_W]; // R7
  assign threshold_inputs_16_19 =
    threshold_r[4 * pulse_cfg_pkg::THR_W +: pulse_cfg_pkg::THR_W]; // R7
  assign threshold_inputs_20_23 =
    threshold_r[5 * pulse_cfg_pkg::THR_W +: pulse_cfg_pkg::THR_W]; // R7
  assign thr_groups = {threshold_inputs_20_23, threshold_inputs_16_19,
                       threshold_inputs_12_15, threshold_inputs_8_11,
                       threshold_inputs_4_7, threshold_inputs_0_3}; // R8

  // Spread group level bits and threshold codes over the inputs
  for (genvar i = 0; i < pulse_cfg_pkg::N_INPUTS; i++) begin : g_in
    assign level_per_input[i] =
      level_groups[group_of(i, pulse_cfg_pkg::LEVEL_GROUP_SIZE)];
    assign thr_per_input[pulse_cfg_pkg::THR_W * i +: pulse_cfg_pkg::THR_W] =
      thr_groups[pulse_cfg_pkg::THR_W *
                 group_of(i, pulse_cfg_pkg::THR_GROUP_SIZE) +:
                 pulse_cfg_pkg::THR_W];
  end

  // Duration timer, takes the duration code when a pulse starts
  pulse_timer i_pulse_timer (
    .ref_clk  (ref_clk),
    .rst      (rst),
    .start    (pulse_start),
    .dur_code (dur_field), // R1
    .active   (timer_active)
  );

  // Current source drive, switched on only while the timer runs
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      drive <= '0;
    end else begin
      drive.on         <= timer_active ? input_enable_r
                                       : 24'h000000; // R6 R10
      drive.high_level <= level_per_input; // R10
    end
  end

  // Duration code as seen by the pulse logic
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      pulse_duration_code <= 3'h0;
    end else begin
      pulse_duration_code <= dur_field; // R1
    end
  end

  // Threshold code of every input for the comparators
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      threshold_per_input <= 48'h000000000000;
    end else begin
      threshold_per_input <= thr_per_input; // R8
    end
  end

  // Busy flag follows the timer, in step with the drive
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      pulse_busy <= 1'h0;
    end else begin
      pulse_busy <= timer_active; // R10
    end
  end

endmodule : pulse_threshold_cfg

/* pulse_threshold_cfg_chk.sv */
// Assertion checker for the pulse and threshold configuration block
`timescale 1ns/1ps
module pulse_threshold_cfg_chk (
  input wire logic                        ref_clk,
  input wire logic                        rst,
  input wire pulse_cfg_pkg::reg_req_t     req,
  input wire logic                        pulse_start,
  input wire logic [23:0]                 rdata,
  input wire logic                        rvalid,
  input wire pulse_cfg_pkg::pulse_drive_t drive,
  input wire logic [2:0]                  pulse_duration_code,
  input wire logic [47:0]                 threshold_per_input,
  input wire logic                        pulse_busy
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  logic [47:0] t;
  logic [23:0] h;
  logic [17:0] run_r;
  logic [2:0]  code_r;
  // Short names for the group checks
  assign t = threshold_per_input;
  assign h = drive.high_level;
  sequence rd_answer; ##1 rvalid; endsequence
  sequence busy_run; pulse_busy [*8]; endsequence
  // Length of the running pulse and the code held just before it
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      run_r  <= 18'h00000;
      code_r <= 3'h0;
    end else begin
      run_r <= pulse_busy ? run_r + 18'h00001 : 18'h00000;
      if (!pulse_busy) code_r <= pulse_duration_code;
    end
  end
  a_read_answer: assert property (req.rd |-> rd_answer)
    else $error("read strobe not answered");
  a_time_rsvd: assert property (rvalid &&
    $past(req.addr) == pulse_cfg_pkg::OFS_TIME_LEVEL
    |-> rdata[23:7] == 17'h00000) else $error("time reserved set");
  a_thr_rsvd: assert property (rvalid &&
    $past(req.addr) == pulse_cfg_pkg::OFS_THRESHOLD
    |-> rdata[23:12] == 12'h000) else $error("thr reserved set");
  a_idle_off: assert property (!pulse_busy |-> drive.on == 24'h000000)
    else $error("current on while idle");
  a_start_busy: assert property ($rose(pulse_busy)
    |-> $past(pulse_start, 2)) else $error("pulse without start");
  a_busy_hold: assert property ($rose(pulse_busy) |-> busy_run)
    else $error("pulse too short");
  a_busy_length: assert property ($fell(pulse_busy)
    |-> run_r == 18'((32'(code_r) + 1) * pulse_cfg_pkg::STEP_CYCLES))
    else $error("pulse length wrong");
  a_level_group: assert property (h == {{6{h[18]}}, {6{h[12]}},
    {6{h[6]}}, {6{h[0]}}}) else $error("level not per group");
  a_thr_group: assert property (t == {{4{t[41:40]}}, {4{t[33:32]}},
    {4{t[25:24]}}, {4{t[17:16]}}, {4{t[9:8]}}, {4{t[1:0]}}})
    else $error("threshold not per group");
endmodule : pulse_threshold_cfg_chk

/* host_mcu.sv */
// Host model issuing register strobes and pulse requests
`timescale 1ns/1ps
module host_mcu (
  input  wire logic                   ref_clk,
  output pulse_cfg_pkg::reg_req_t     req,
  output logic                        pulse_start
);
  // Idle bus at time zero
  initial begin
    req = '0;
    pulse_start = 1'b0;
  end
  // One-cycle strobe; released data is inverted so it is never reused
  task acc(input logic w, input logic [5:0] a, input logic [23:0] d);
    @(negedge ref_clk);
    req = {w, !w, a, d};
    @(negedge ref_clk);
    req.wr = 1'b0;
    req.rd = 1'b0;
    req.wdata = ~d;
  endtask : acc
  // One-cycle pulse request
  task pulse;
    @(negedge ref_clk);
    pulse_start = 1'b1;
    @(negedge ref_clk);
    pulse_start = 1'b0;
  endtask : pulse
endmodule : host_mcu

/* pulse_threshold_cfg_tb.sv */
// Testbench for the pulse and threshold configuration block
`timescale 1ns/1ps
module pulse_threshold_cfg_tb;
  logic                        ref_clk = 1'b0;
  logic                        rst = 1'b1;
  pulse_cfg_pkg::reg_req_t     req;
  logic                        pulse_start, rvalid, pulse_busy;
  logic [23:0]                 rdata;
  pulse_cfg_pkg::pulse_drive_t drive;
  logic [2:0]                  dur;
  logic [47:0]                 thr, e;
  int                          n_fail = 0, n_checks = 0, i;
  // 250 MHz clock
  always #2 ref_clk = ~ref_clk;
  host_mcu i_host_mcu (.ref_clk(ref_clk), .req(req),
    .pulse_start(pulse_start));
  pulse_threshold_cfg i_pulse_threshold_cfg (.ref_clk(ref_clk), .rst(rst),
    .req(req), .pulse_start(pulse_start), .rdata(rdata), .rvalid(rvalid),
    .drive(drive), .pulse_duration_code(dur), .threshold_per_input(thr),
    .pulse_busy(pulse_busy));
  task chk(input logic [55:0] g, input logic [55:0] x);
    n_checks++;
    if (g !== x) begin
      n_fail++;
      $display("CHECK FAILED %0t got %h exp %h", $time, g, x);
    end
  endtask : chk
  task rd(input logic [5:0] a, input logic [23:0] x);
    i_host_mcu.acc(1'b0, a, 24'h000000);
    chk({rvalid, rdata}, {1'b1, x});
  endtask : rd
  task t_regs;
    for (i = 0; i < 3; i++) begin
      rd(6'h1F + i[5:0], 24'h000000);
      i_host_mcu.acc(1'b1, 6'h1F + i[5:0], 24'hFFFFFF);
    end
    rd(6'h1F, 24'h00007F);
    rd(6'h20, 24'hFFFFFF);
    rd(6'h21, 24'h000FFF);
    rd(6'h22, 24'h000000);
  endtask : t_regs
  task t_thr;
    i_host_mcu.acc(1'b1, 6'h21, 24'h000E1B);
    repeat (2) @(negedge ref_clk);
    for (i = 0; i < 24; i++) e[2*i +: 2] = 2'(12'hE1B >> (2 * (i / 4)));
    chk(thr, e);
    chk(dur, 3'h7);
  endtask : t_thr
  task t_pulse;
    i_host_mcu.acc(1'b1, 6'h1F, 24'h000005);
    i_host_mcu.acc(1'b1, 6'h20, 24'hA5A5A5);
    i_host_mcu.pulse;
    repeat (2) @(negedge ref_clk);
    chk({dur, drive}, {3'h0, 24'hA5A5A5, 24'h03F03F});
    i_host_mcu.pulse;
    repeat (15996) @(negedge ref_clk);
    chk(pulse_busy, 1'b1);
    @(negedge ref_clk);
    chk({pulse_busy, drive.on}, 25'h0000000);
  endtask : t_pulse
  task stop_test;
    if (n_fail == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : stop_test
  // Reset, then the scenarios
  initial begin
    repeat (3) @(negedge ref_clk);
    rst = 1'b0;
    t_regs;
    t_thr;
    t_pulse;
    stop_test;
  end
  // Watchdog against a hang
  initial begin
    #100000;
    n_fail++;
    stop_test;
  end
endmodule : pulse_threshold_cfg_tb
bind pulse_threshold_cfg pulse_threshold_cfg_chk i_pulse_threshold_cfg_chk (
  .ref_clk(ref_clk), .rst(rst), .req(req), .pulse_start(pulse_start),
  .rdata(rdata), .rvalid(rvalid), .drive(drive),
  .pulse_duration_code(pulse_duration_code),
  .threshold_per_input(threshold_per_input), .pulse_busy(pulse_busy));
